// file: logic/adc_ctrl_pkg.sv
/*
  Constants for the converter clock and sequence control block.
  Assumes one module clock and a synchronous active-high reset.
*/
// Overview of operation
// - Three clocks come from the one module clock: analog input, time-base, digital.
// - Time-base clock derives from analog input clock with even duty cycle.
// - Two-bit divider select: 00 /2, 01 /3, 10 /4, 11 /32, default 11.
// - Each conversion runs sync, sample, convert, then write result.
// - Successive approximation on one of eight multiplexed input channels.
// - Resolution is selectable as eight or ten bits.
// - Four independent result registers hold the outcomes.
// - Wait-for-read stops an unread result from being overwritten.
// - Filter can add two successive results before presenting them.
// - Two request sources arbitrated by programmable priority.
// - A running conversion can be cancelled and restarted.
// - Results are checked against limits and out-of-range is reported.
package adc_ctrl_pkg;

  // ------------------------------------------------------------
  // Divider select codes and ratios
  // ------------------------------------------------------------
  localparam logic [1:0] DIV_SEL_2     = 2'h0;
  localparam logic [1:0] DIV_SEL_3     = 2'h1;
  localparam logic [1:0] DIV_SEL_4     = 2'h2;
  localparam logic [1:0] DIV_SEL_32    = 2'h3;
  localparam logic [1:0] DIV_SEL_RESET = DIV_SEL_32;
  localparam logic [4:0] RATIO_2       = 5'h01;
  localparam logic [4:0] RATIO_3       = 5'h02;
  localparam logic [4:0] RATIO_4       = 5'h03;
  localparam logic [4:0] RATIO_32      = 5'h1F;

  // ------------------------------------------------------------
  // Sequence timing in analog input clock cycles
  // ------------------------------------------------------------
  localparam logic [3:0] SYNC_CYCLES   = 4'h2;
  localparam logic [3:0] WRITE_CYCLES  = 4'h1;
  localparam logic [3:0] BITS_HI_RES   = 4'hA;
  localparam logic [3:0] BITS_LO_RES   = 4'h8;

  // ------------------------------------------------------------
  // Field widths
  // ------------------------------------------------------------
  localparam int RES_W    = 10;
  localparam int SUM_W    = 11;
  localparam int NUM_RES  = 4;
  localparam int NUM_CH   = 8;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SYNC = 5'h02,
    ST_SAMP = 5'h04,
    ST_CONV = 5'h08,
    ST_WRIT = 5'h10
  } seq_state_t;

endpackage : adc_ctrl_pkg

// file: logic/adc_clock_and_sequence_control.sv
/*
  Converter clock prescaler and conversion sequencer.
  Assumes the analog core answers each trial bit with a comparator level on
  the same module clock and that requests are synchronous to clk.
*/
`timescale 1ns/100ps
module adc_clock_and_sequence_control (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Configuration
  input  wire logic [1:0]                    analog_clock_divider_select,
  input  wire logic                          res_8bit,
  input  wire logic [3:0]                    sample_cycles,
  input  wire logic                          wait_for_read,
  input  wire logic                          filter_en,
  input  wire logic                          src_b_priority,
  input  wire logic [9:0]                    limit_lo,
  input  wire logic [9:0]                    limit_hi,
  // Requests
  input  wire logic                          req_a,
  input  wire logic [2:0]                    chan_a,
  input  wire logic [1:0]                    dest_a,
  input  wire logic                          req_b,
  input  wire logic [2:0]                    chan_b,
  input  wire logic [1:0]                    dest_b,
  input  wire logic                          cancel,
  // Result read side
  input  wire logic [1:0]                    read_sel,
  input  wire logic                          read_strobe,
  output logic [10:0]                        read_data,
  output logic [3:0]                         result_valid,
  // Analog core
  output logic                               analog_input_clock,
  output logic                               analog_timebase_clock,
  output logic                               converter_digital_clock,
  output logic [2:0]                         mux_sel,
  output logic                               sample_en,
  output logic [9:0]                         trial_code,
  input  wire logic                          comp_high,
  // Status
  output logic                               busy,
  output logic                               grant_b,
  output logic                               conv_done,
  output logic                               limit_fail
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [4:0]                 pre_cnt;
    logic                       ain_clk;
    logic                       tb_clk;
    logic                       tick;
    adc_ctrl_pkg::seq_state_t   st;
    logic [3:0]                 cnt;
    logic [2:0]                 chan;
    logic [1:0]                 dest;
    logic                       src_b;
    logic [9:0]                 sar;
    logic [3:0]                 bit_idx;
    logic [3:0]                 valid;
    logic [4*11-1:0]            res;
    logic [3:0]                 acc_half;
    logic [10:0]                rd;
    logic                       done;
    logic                       lim;
  } state_t;

  state_t cur_r;
  state_t cur_nxt;

  function automatic logic [4:0] ratio_of(input logic [1:0] sel);
    case (sel)
      adc_ctrl_pkg::DIV_SEL_2: ratio_of = adc_ctrl_pkg::RATIO_2;
      adc_ctrl_pkg::DIV_SEL_3: ratio_of = adc_ctrl_pkg::RATIO_3;
      adc_ctrl_pkg::DIV_SEL_4: ratio_of = adc_ctrl_pkg::RATIO_4;
      default:                 ratio_of = adc_ctrl_pkg::RATIO_32;
    endcase
  endfunction : ratio_of

  logic [3:0]  bit_pos;
  logic [10:0] slot_val;
  logic [10:0] new_val;
  logic        slot_busy;

  // Eight-bit mode resolves the top eight bits, so its trial position sits two places higher.
  assign bit_pos = res_8bit ? (cur_r.bit_idx + 4'h1) : (cur_r.bit_idx + 4'hF);

  always_comb begin
    cur_nxt      = cur_r;
    cur_nxt.done = 1'b0;
    cur_nxt.lim  = 1'b0;
    cur_nxt.tick = 1'b0;
    if (cur_r.pre_cnt >= ratio_of(analog_clock_divider_select)) begin
      cur_nxt.pre_cnt = 5'h00;
      cur_nxt.ain_clk = 1'b1;
      cur_nxt.tick    = 1'b1;
    end else begin
      cur_nxt.pre_cnt = cur_r.pre_cnt + 5'h01;
      cur_nxt.ain_clk = 1'b0;
    end
    // Toggle halves the rate for an even duty cycle.
    if (cur_r.ain_clk) begin
      cur_nxt.tb_clk = ~cur_r.tb_clk;
    end
    slot_val  = cur_r.res[cur_r.dest*11 +: 11];
    slot_busy = cur_r.valid[cur_r.dest];
    new_val   = {1'b0, cur_r.sar};
    // Read clears valid; set by a write wins below.
    if (read_strobe) begin
      cur_nxt.rd                = cur_r.res[read_sel*11 +: 11];
      cur_nxt.valid[read_sel]   = 1'b0;
    end
    if (cancel && cur_r.st != adc_ctrl_pkg::ST_IDLE) begin
      cur_nxt.st = adc_ctrl_pkg::ST_IDLE;
    end else begin
      case (cur_r.st)
        adc_ctrl_pkg::ST_IDLE: begin
          if (req_a || req_b) begin
            cur_nxt.src_b = req_b && (src_b_priority || !req_a);
            cur_nxt.chan  = cur_nxt.src_b ? chan_b : chan_a;
            cur_nxt.dest  = cur_nxt.src_b ? dest_b : dest_a;
            cur_nxt.cnt   = 4'h0;
            cur_nxt.st    = adc_ctrl_pkg::ST_SYNC;
          end
        end
        adc_ctrl_pkg::ST_SYNC: begin
          if (cur_r.tick) begin
            if (cur_r.cnt + 4'h1 >= adc_ctrl_pkg::SYNC_CYCLES) begin
              cur_nxt.cnt = 4'h0;
              cur_nxt.st  = adc_ctrl_pkg::ST_SAMP;
            end else begin
              cur_nxt.cnt = cur_r.cnt + 4'h1;
            end
          end
        end
        adc_ctrl_pkg::ST_SAMP: begin
          if (cur_r.tick) begin
            if (cur_r.cnt >= sample_cycles) begin
              cur_nxt.st      = adc_ctrl_pkg::ST_CONV;
              cur_nxt.bit_idx = res_8bit ? adc_ctrl_pkg::BITS_LO_RES : adc_ctrl_pkg::BITS_HI_RES;
              cur_nxt.sar     = 10'h000;
            end else begin
              cur_nxt.cnt = cur_r.cnt + 4'h1;
            end
          end
        end
        // One successive-approximation bit per analog input clock tick.
        // Eight-bit mode resolves the top eight bits only.
        adc_ctrl_pkg::ST_CONV: begin
          if (cur_r.tick) begin
            if (comp_high) begin
              cur_nxt.sar[bit_pos] = 1'b1;
            end
            cur_nxt.bit_idx = cur_r.bit_idx - 4'h1;
            if (cur_r.bit_idx == 4'h1) begin
              cur_nxt.st = adc_ctrl_pkg::ST_WRIT;
            end
          end
        end
        adc_ctrl_pkg::ST_WRIT: begin
          // Hold off while an unread result waits.
          if (!(wait_for_read && slot_busy && !(read_strobe && read_sel == cur_r.dest))) begin
            // Sum two successive results when the filter is on.
            if (filter_en && cur_r.acc_half[cur_r.dest]) begin
              new_val                     = slot_val + {1'b0, cur_r.sar};
              cur_nxt.acc_half[cur_r.dest] = 1'b0;
            end else if (filter_en) begin
              cur_nxt.acc_half[cur_r.dest] = 1'b1;
            end
            cur_nxt.res[cur_r.dest*11 +: 11] = new_val;
            if (!filter_en || cur_r.acc_half[cur_r.dest]) begin
              cur_nxt.valid[cur_r.dest] = 1'b1;
              cur_nxt.done              = 1'b1;
            end
            cur_nxt.lim = (cur_r.sar < limit_lo) || (cur_r.sar > limit_hi);
            cur_nxt.st  = adc_ctrl_pkg::ST_IDLE;
          end
        end
        default: cur_nxt.st = adc_ctrl_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur_r          <= '0;
      cur_r.st       <= adc_ctrl_pkg::ST_IDLE;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign analog_input_clock      = cur_r.ain_clk;
  assign analog_timebase_clock   = cur_r.tb_clk;
  assign converter_digital_clock = clk;
  assign mux_sel                 = cur_r.chan;
  assign sample_en               = (cur_r.st == adc_ctrl_pkg::ST_SAMP);
  assign trial_code              = (cur_r.st == adc_ctrl_pkg::ST_CONV && cur_r.bit_idx != 4'h0)
                                   ? (cur_r.sar | (10'h001 << bit_pos)) : cur_r.sar;
  assign busy                    = (cur_r.st != adc_ctrl_pkg::ST_IDLE);
  assign grant_b                 = cur_r.src_b;
  assign conv_done               = cur_r.done;
  assign limit_fail              = cur_r.lim;
  assign read_data               = cur_r.rd;
  assign result_valid            = cur_r.valid;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_conv_end;
    cur_r.st == adc_ctrl_pkg::ST_CONV ##1 cur_r.st == adc_ctrl_pkg::ST_WRIT;
  endsequence

  chk_prescale_wrap: assert property (@(posedge clk) disable iff (rst)
    cur_r.ain_clk |-> cur_r.pre_cnt == 5'h00)
    else $error("prescaler pulse without wrap");
  chk_tb_toggle: assert property (@(posedge clk) disable iff (rst)
    cur_r.ain_clk |=> cur_r.tb_clk != $past(cur_r.tb_clk))
    else $error("timebase did not toggle");
  chk_phase_order: assert property (@(posedge clk) disable iff (rst)
    (cur_r.st == adc_ctrl_pkg::ST_SAMP && !cancel) |=> cur_r.st inside {adc_ctrl_pkg::ST_SAMP, adc_ctrl_pkg::ST_CONV})
    else $error("sample phase left wrongly");
  chk_conv_to_write: assert property (@(posedge clk) disable iff (rst)
    s_conv_end |-> $past(cur_r.bit_idx) == 4'h1)
    else $error("conversion ended early");
  chk_cancel_idle: assert property (@(posedge clk) disable iff (rst)
    (cancel && busy) |=> !busy)
    else $error("cancel ignored");
  chk_done_valid: assert property (@(posedge clk) disable iff (rst)
    conv_done |-> result_valid != 4'h0)
    else $error("done without valid result");
  chk_prio_b: assert property (@(posedge clk) disable iff (rst)
    (!busy && req_a && req_b && src_b_priority && !cancel) |=> grant_b)
    else $error("priority not honoured");
  chk_res8_bits: assert property (@(posedge clk) disable iff (rst)
    (cur_r.st == adc_ctrl_pkg::ST_SAMP && cur_r.tick && cur_r.cnt >= sample_cycles && res_8bit && !cancel)
      |=> cur_r.bit_idx == adc_ctrl_pkg::BITS_LO_RES)
    else $error("eight-bit length wrong");
  chk_limit_lo: assert property (@(posedge clk) disable iff (rst)
    (cur_r.st == adc_ctrl_pkg::ST_WRIT && cur_nxt.st == adc_ctrl_pkg::ST_IDLE && cur_r.sar < limit_lo && !cancel)
      |=> limit_fail)
    else $error("limit violation not reported");

endmodule : adc_clock_and_sequence_control

// file: verif/analog_core_model.sv
/*
  Behavioural sample-and-hold and comparator facing the sequencer.
  Assumes trial_code settles within the module clock cycle it is driven.
*/
`timescale 1ns/100ps
module analog_core_model (
  // Clock
  input  wire logic        clk,
  // Channel levels, ten bits per channel
  input  wire logic [79:0] levels,
  // Sequencer side
  input  wire logic [2:0]  mux_sel,
  input  wire logic        sample_en,
  input  wire logic [9:0]  trial_code,
  output logic             comp_high
);
  logic [9:0] held_r;

  // hold selected channel
  // The level is frozen at the end of sampling, as a real hold capacitor would be.
  always_ff @(posedge clk) begin
    if (sample_en) begin
      held_r <= levels[mux_sel*10 +: 10];
    end
  end

  assign comp_high = (held_r >= trial_code);
endmodule : analog_core_model

// file: verif/adc_clock_and_sequence_control_test.sv
/*
  Self-checking bench for the converter clock and sequence control block.
  Assumes the analog core model sits on the sequencer's analog side.
*/
`timescale 1ns/100ps
module adc_clock_and_sequence_control_test;
  logic clk, rst, res_8bit, wait_for_read, filter_en, src_b_priority, req_a, req_b, cancel, read_strobe;
  logic [1:0] analog_clock_divider_select, dest_a, dest_b, read_sel;
  logic [3:0] sample_cycles, result_valid;
  logic [9:0] limit_lo, limit_hi, trial_code;
  logic [2:0] chan_a, chan_b, mux_sel;
  logic [10:0] read_data;
  logic [79:0] levels;
  logic aic, atc, dclk, sample_en, comp_high, busy, grant_b, conv_done, limit_fail, seen_fail;
  logic [31:0] rnd;
  int failures, total_checks, n;

  adc_clock_and_sequence_control dut_u (.clk(clk), .rst(rst),
    .analog_clock_divider_select(analog_clock_divider_select), .res_8bit(res_8bit),
    .sample_cycles(sample_cycles), .wait_for_read(wait_for_read), .filter_en(filter_en),
    .src_b_priority(src_b_priority), .limit_lo(limit_lo), .limit_hi(limit_hi), .req_a(req_a),
    .chan_a(chan_a), .dest_a(dest_a), .req_b(req_b), .chan_b(chan_b), .dest_b(dest_b),
    .cancel(cancel), .read_sel(read_sel), .read_strobe(read_strobe), .read_data(read_data),
    .result_valid(result_valid), .analog_input_clock(aic), .analog_timebase_clock(atc),
    .converter_digital_clock(dclk), .mux_sel(mux_sel), .sample_en(sample_en),
    .trial_code(trial_code), .comp_high(comp_high), .busy(busy), .grant_b(grant_b),
    .conv_done(conv_done), .limit_fail(limit_fail));
  analog_core_model core_u (.clk(clk), .levels(levels), .mux_sel(mux_sel),
    .sample_en(sample_en), .trial_code(trial_code), .comp_high(comp_high));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    total_checks++;
    if (exp !== got) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  // Waits on a design flag under a bound; running out is a mismatch.
  task automatic wait_flag(ref logic f, input logic lvl, input int lim);
    n = 0;
    while (f !== lvl && n < lim) begin
      tick();
      n++;
    end
    if (n >= lim) begin
      chk("wait bound", 11'h000, 11'h001);
      finish_test();
    end
  endtask : wait_flag

  // Starts from source B when use_b, else A, and runs until the sequencer is idle again.
  // Waiting on busy rather than done also covers the first half of a filter pair.
  task automatic convert(input logic use_b, input logic [2:0] ch, input logic [1:0] d);
    chan_a <= ch; dest_a <= d; chan_b <= ch; dest_b <= d;
    req_a <= !use_b; req_b <= use_b;
    tick();
    wait_flag(busy, 1'b1, 8);
    req_a <= 1'b0; req_b <= 1'b0;
    wait_flag(busy, 1'b0, 3000);
    seen_fail = limit_fail;
  endtask : convert

  task automatic read_slot(input logic [1:0] s);
    read_sel <= s; read_strobe <= 1'b1;
    tick();
    read_strobe <= 1'b0;
    tick();
  endtask : read_slot

  logic [9:0] lv;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst = 1'b1; analog_clock_divider_select = 2'h3; res_8bit = 1'b0; sample_cycles = 4'h3;
    wait_for_read = 1'b0; filter_en = 1'b0; src_b_priority = 1'b0; limit_lo = 10'h000;
    limit_hi = 10'h3FF; req_a = 1'b0; req_b = 1'b0; chan_a = 3'h0; chan_b = 3'h0; dest_a = 2'h0;
    dest_b = 2'h0; cancel = 1'b0; read_sel = 2'h0; read_strobe = 1'b0; rnd = 32'h5fc6;
    failures = 0; total_checks = 0;
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      levels[i*10 +: 10] = 10'h010 + {2'h0, rnd[7:0]} * 10'h003;
    end
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // ------------------------------------------------------------
    // Prescaler ratios
    // ------------------------------------------------------------
    for (int c = 3; c >= 0; c--) begin
      analog_clock_divider_select <= c[1:0];
      repeat (40) tick();
      wait_flag(aic, 1'b1, 40);
      lv = {9'h000, atc};
      tick();
      wait_flag(aic, 1'b1, 40);
      chk("tick period", (c == 3) ? 11'h020 : 11'h002 + c[10:0], 11'h001 + n[10:0]);
      chk("timebase toggle", {10'h000, !lv[0]}, {10'h000, atc});
    end
    // keep time-base slow
    // At this module clock only divide by 32 keeps the time-base under its ceiling, so every
    // conversion runs there; the faster codes are only timed while idle.
    analog_clock_divider_select <= 2'h3;
    tick();
    // ------------------------------------------------------------
    // Random conversions into every slot, from both sources
    // ------------------------------------------------------------
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      lv = levels[rnd[2:0]*10 +: 10];
      src_b_priority <= rnd[5];
      convert(rnd[4], rnd[2:0], k[1:0]);
      chk("mux", {8'h00, rnd[2:0]}, {8'h00, mux_sel});
      chk("grant", {10'h000, rnd[4]}, {10'h000, grant_b});
      tick();
      chk("valid set", 11'h001, {10'h000, result_valid[k[1:0]]});
      read_slot(k[1:0]);
      chk("result", {1'b0, lv}, read_data);
      chk("valid clear", 11'h000, {10'h000, result_valid[k[1:0]]});
    end
    // ------------------------------------------------------------
    // Limit check, priority, filter, cancel
    // ------------------------------------------------------------
    lv = levels[9:0];
    limit_hi <= lv - 10'h001;
    convert(1'b0, 3'h0, 2'h1);
    chk("limit fail", 11'h001, {10'h000, seen_fail});
    limit_hi <= 10'h3FF;
    read_slot(2'h1);
    limit_lo <= lv + 10'h001;
    convert(1'b0, 3'h0, 2'h1);
    chk("limit low fail", 11'h001, {10'h000, seen_fail});
    limit_lo <= 10'h000;
    read_slot(2'h1);
    src_b_priority <= 1'b1;
    req_a <= 1'b1; req_b <= 1'b1;
    tick();
    wait_flag(busy, 1'b1, 8);
    chk("grant b", 11'h001, {10'h000, grant_b});
    req_a <= 1'b0; req_b <= 1'b0;
    wait_flag(busy, 1'b0, 3000);
    filter_en <= 1'b1;
    convert(1'b0, 3'h0, 2'h2);
    convert(1'b0, 3'h0, 2'h2);
    tick();
    read_slot(2'h2);
    chk("filter sum", {1'b0, lv} + {1'b0, lv}, read_data);
    filter_en <= 1'b0;
    req_a <= 1'b1;
    tick();
    wait_flag(busy, 1'b1, 8);
    req_a <= 1'b0;
    repeat (6) tick();
    cancel <= 1'b1;
    tick();
    cancel <= 1'b0;
    wait_flag(busy, 1'b0, 6);
    chk("cancel done", 11'h000, {10'h000, conv_done});
    convert(1'b0, 3'h0, 2'h3);
    chk("restart", 11'h001, {10'h000, conv_done});
    // Slot 1 still holds the unread priority result from channel 0.
    wait_for_read <= 1'b1;
    chan_a <= 3'h1; dest_a <= 2'h1; req_a <= 1'b1;
    tick();
    wait_flag(busy, 1'b1, 8);
    req_a <= 1'b0;
    repeat (700) tick();
    chk("write held off", 11'h001, {10'h000, busy});
    read_slot(2'h1);
    chk("unread kept", {1'b0, levels[9:0]}, read_data);
    wait_flag(busy, 1'b0, 8);
    read_slot(2'h1);
    chk("write after read", {1'b0, levels[19:10]}, read_data);
    wait_for_read <= 1'b0;
    res_8bit <= 1'b1;
    convert(1'b0, 3'h2, 2'h0);
    read_slot(2'h0);
    chk("eight-bit result", {1'b0, levels[29:20] & 10'h3FC}, read_data);
    res_8bit <= 1'b0;
    finish_test();
  end
endmodule : adc_clock_and_sequence_control_test
